// ===== fpmac_pkg.sv
// constants and types for the fixed-point multiply-accumulate datapath
package fpmac_pkg;

  localparam int DATA_W  = 32;
  localparam int HALF_W  = 16;
  localparam int ACC_W   = 64;
  localparam int NUM_ACC = 4;
  localparam int ACC_SEL_W = 2;
  localparam int NUM_PROD  = 4;

  // product slots: straight upper, straight lower, crossed a-hi/b-lo, crossed a-lo/b-hi
  localparam int PROD_HI   = 0;
  localparam int PROD_LO   = 1;
  localparam int PROD_XHL  = 2;
  localparam int PROD_XLH  = 3;

  localparam logic [HALF_W-1:0] Q15_MINUS_ONE = 16'h8000;
  localparam logic [HALF_W-1:0] H16_MAX       = 16'h7fff;
  localparam logic [HALF_W-1:0] H16_MIN       = 16'h8000;
  localparam logic [DATA_W-1:0] Q31_MINUS_ONE = 32'h8000_0000;
  localparam logic [DATA_W-1:0] Q31_MAX       = 32'h7fff_ffff;
  localparam logic [ACC_W-1:0]  Q31_MAX_ACC   = 64'h0000_0000_7fff_ffff;
  localparam logic [ACC_W-1:0]  Q31_MIN_ACC   = 64'hffff_ffff_8000_0000;
  localparam logic [ACC_W-1:0]  Q63_MAX       = 64'h7fff_ffff_ffff_ffff;
  localparam logic [ACC_W-1:0]  ACC_MAX       = 64'h7fff_ffff_ffff_ffff;
  localparam logic [ACC_W-1:0]  ACC_MIN       = 64'h8000_0000_0000_0000;
  localparam logic [ACC_W-1:0]  ACC_RESET     = 64'h0000_0000_0000_0000;
  localparam logic [DATA_W-1:0] DEST_RESET    = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_DOT_SUB       = 4'h0,
    OP_CROSS_SUB     = 4'h1,
    OP_CROSS_SUB_SAT = 4'h2,
    OP_CMPLX_STEP    = 4'h3,
    OP_LONG_ACC_SAT  = 4'h4,
    OP_LONG_SUB_SAT  = 4'h5,
    OP_LEFT_MAC      = 4'h6,
    OP_RIGHT_MAC     = 4'h7,
    OP_LEFT_MAC_SAT  = 4'h8,
    OP_RIGHT_MAC_SAT = 4'h9,
    OP_LANE_MUL      = 4'ha,
    OP_LANE_MUL_SAT  = 4'hb
  } fpmac_op_e;

endpackage : fpmac_pkg

// ===== fpmac_q15_mul.sv
// one signed halfword multiplier with integer and clamped Q31 results
`timescale 1ns/1ps
`default_nettype none
module fpmac_q15_mul
  import fpmac_pkg::*;
(
  input  wire logic [HALF_W-1:0] a,         // first multiplicand
  input  wire logic [HALF_W-1:0] b,         // second multiplicand
  output logic      [DATA_W-1:0] intProd,   // signed 32-bit integer product
  output logic      [DATA_W-1:0] fracProd,  // product doubled, Q31
  output logic                   clamped    // both multiplicands minus one
);

  logic signed [DATA_W-1:0] product;

  assign product  = $signed(a) * $signed(b);
  assign intProd  = product;
  assign clamped  = (a == Q15_MINUS_ONE) && (b == Q15_MINUS_ONE);
  // doubling -1 * -1 overflows, so that case takes the largest Q31 value
  assign fracProd = clamped ? Q31_MAX : {product[DATA_W-2:0], 1'b0};

endmodule : fpmac_q15_mul
`default_nettype wire

// ===== fpmac_datapath.sv
// fixed-point multiply and multiply-accumulate datapath with four accumulators
// Operation
// - dot subtract multiplies both Q15 pairs, doubling each into Q31
// - a product of minus one by minus one becomes largest Q31
// - straight dot subtract sign-extends both products, sums, subtracts from accumulator
// - crossed dot subtract pairs upper with lower, sums, subtracts from accumulator
// - saturating crossed subtract clamps the accumulator to its full range
// - complex step adds upper product minus lower product to accumulator
// - complex step clamps each minus-one-squared product before subtraction
// - long forms multiply Q31 operands into Q63, clamping minus one squared
// - long accumulate adds the Q63 product to the accumulator
// - long subtract takes the Q63 product from the accumulator
// - long forms saturate accumulator overflow to largest or most negative
// - halfword MAC sign-extends one Q15 product and adds to accumulator
// - halfword MAC clamps minus one squared to largest Q31
// - saturating halfword MAC clamps accumulated value to Q31 range
// - lane multiply writes low 16 bits of each 32-bit lane product
// - saturating lane multiply clamps lanes that do not fit 16 bits
// - second-revision operations run only when that revision is enabled
// - accumulator operations select one of four accumulators
`timescale 1ns/1ps
`default_nettype none
module fpmac_datapath
  import fpmac_pkg::*;
(
  input  wire logic                 clk,          // processor clock
  input  wire logic                 reset_n,      // asynchronous reset, active low
  input  wire logic                 revisionTwo,  // second-revision operations enabled
  input  wire logic                 opValid,      // operation issued this cycle
  input  wire logic [3:0]           opCode,       // operation code
  input  wire logic [ACC_SEL_W-1:0] accSelect,    // target accumulator
  input  wire logic [DATA_W-1:0]    firstSource,  // first source register value
  input  wire logic [DATA_W-1:0]    secondSource, // second source register value
  input  wire logic [NUM_ACC-1:0]   ovfClear,     // clear sticky overflow flags
  input  wire logic [ACC_SEL_W-1:0] accReadSel,   // accumulator read select
  output logic      [ACC_W-1:0]     accReadData,  // accumulator read data
  output logic                      resultValid,  // result pulse
  output logic                      resultToAcc,  // result went to an accumulator
  output logic      [ACC_W-1:0]     accResult,    // value written to accumulator
  output logic      [DATA_W-1:0]    destResult,   // destination register value
  output logic                      illegalOp,    // refused operation pulse
  output logic      [NUM_ACC-1:0]   ovfFlag       // sticky overflow per accumulator
);

  typedef struct packed {
    logic [NUM_ACC-1:0][ACC_W-1:0] acc;
    logic [NUM_ACC-1:0]            ovf;
    logic [ACC_W-1:0]              readData;
    logic [ACC_W-1:0]              accResult;
    logic [DATA_W-1:0]             destResult;
    logic                          resultValid;
    logic                          resultToAcc;
    logic                          illegalOp;
  } fpmac_state_s;

  fpmac_state_s st;
  fpmac_state_s next_st;

  logic [NUM_PROD-1:0][HALF_W-1:0] mulA;
  logic [NUM_PROD-1:0][HALF_W-1:0] mulB;
  logic [NUM_PROD-1:0][DATA_W-1:0] intProd;
  logic [NUM_PROD-1:0][DATA_W-1:0] fracProd;
  logic [NUM_PROD-1:0]             clamped;

  logic [ACC_W-1:0]        accNow;
  logic [ACC_W-1:0]        straightSum;
  logic [ACC_W-1:0]        crossSum;
  logic [ACC_W-1:0]        cmplxDiff;
  logic signed [ACC_W-1:0] longProd;
  logic                    longClamp;
  logic [ACC_W-1:0]        fracLong;
  logic [ACC_W:0]          wideSum;
  logic [ACC_W-1:0]        wrapSum;
  logic                    wideOvf;
  logic                    revOp;
  logic [DATA_W-1:0]       laneTrunc;

  // operand routing for the four products
  assign mulA[PROD_HI]  = firstSource[DATA_W-1:HALF_W];
  assign mulB[PROD_HI]  = secondSource[DATA_W-1:HALF_W];
  assign mulA[PROD_LO]  = firstSource[HALF_W-1:0];
  assign mulB[PROD_LO]  = secondSource[HALF_W-1:0];
  assign mulA[PROD_XHL] = firstSource[DATA_W-1:HALF_W];
  assign mulB[PROD_XHL] = secondSource[HALF_W-1:0];
  assign mulA[PROD_XLH] = firstSource[HALF_W-1:0];
  assign mulB[PROD_XLH] = secondSource[DATA_W-1:HALF_W];

  generate
    for (genvar i = 0; i < NUM_PROD; i++)
    begin : g_mul
      fpmac_q15_mul u_mul (
        .a        (mulA[i]),
        .b        (mulB[i]),
        .intProd  (intProd[i]),
        .fracProd (fracProd[i]),
        .clamped  (clamped[i])
      );
    end
  endgenerate

  assign accNow      = st.acc[accSelect];
  assign straightSum = {{32{fracProd[PROD_HI][DATA_W-1]}}, fracProd[PROD_HI]}
                     + {{32{fracProd[PROD_LO][DATA_W-1]}}, fracProd[PROD_LO]};
  assign crossSum    = {{32{fracProd[PROD_XHL][DATA_W-1]}}, fracProd[PROD_XHL]}
                     + {{32{fracProd[PROD_XLH][DATA_W-1]}}, fracProd[PROD_XLH]};
  assign cmplxDiff   = {{32{fracProd[PROD_HI][DATA_W-1]}}, fracProd[PROD_HI]}
                     - {{32{fracProd[PROD_LO][DATA_W-1]}}, fracProd[PROD_LO]};
  assign longProd    = $signed(firstSource) * $signed(secondSource);
  assign longClamp   = (firstSource == Q31_MINUS_ONE) && (secondSource == Q31_MINUS_ONE);
  assign fracLong    = longClamp ? Q63_MAX : {longProd[ACC_W-2:0], 1'b0};
  assign revOp       = (opCode == OP_CROSS_SUB_SAT) || (opCode == OP_LANE_MUL)
                    || (opCode == OP_LANE_MUL_SAT);
  assign laneTrunc   = {intProd[PROD_HI][HALF_W-1:0], intProd[PROD_LO][HALF_W-1:0]};

  // shared 65-bit adder; operand and sense chosen by the operation
  always_comb
  begin
    logic [ACC_W-1:0] addend;
    logic             subtract;
    addend   = straightSum;
    subtract = (opCode == OP_DOT_SUB) || (opCode == OP_CROSS_SUB) || (opCode == OP_CROSS_SUB_SAT)
            || (opCode == OP_LONG_SUB_SAT);
    unique case (opCode)
      OP_DOT_SUB:       addend = straightSum;
      OP_CROSS_SUB,
      OP_CROSS_SUB_SAT: addend = crossSum;
      OP_CMPLX_STEP:    addend = cmplxDiff;
      OP_LONG_ACC_SAT,
      OP_LONG_SUB_SAT:  addend = fracLong;
      OP_LEFT_MAC,
      OP_LEFT_MAC_SAT:  addend = {{32{fracProd[PROD_HI][DATA_W-1]}}, fracProd[PROD_HI]};
      OP_RIGHT_MAC,
      OP_RIGHT_MAC_SAT: addend = {{32{fracProd[PROD_LO][DATA_W-1]}}, fracProd[PROD_LO]};
      default:          addend = straightSum;
    endcase
    if (subtract)
      wideSum = {accNow[ACC_W-1], accNow} - {addend[ACC_W-1], addend};
    else
      wideSum = {accNow[ACC_W-1], accNow} + {addend[ACC_W-1], addend};
  end

  assign wrapSum = wideSum[ACC_W-1:0];
  assign wideOvf = wideSum[ACC_W] != wideSum[ACC_W-1];

  always_comb
  begin
    logic [ACC_W-1:0]  newAcc;
    logic [DATA_W-1:0] lanes;
    logic              sat;
    next_st             = st;
    next_st.resultValid = 1'b0;
    next_st.resultToAcc = 1'b0;
    next_st.illegalOp   = 1'b0;
    next_st.readData    = st.acc[accReadSel];
    next_st.ovf         = st.ovf & ~ovfClear;
    newAcc              = wrapSum;
    lanes               = laneTrunc;
    sat                 = 1'b0;
    if (opValid)
    begin
      if (revOp && !revisionTwo)
      begin
        next_st.illegalOp = 1'b1;
      end
      else if (opCode == OP_LANE_MUL || opCode == OP_LANE_MUL_SAT)
      begin
        if (opCode == OP_LANE_MUL_SAT)
        begin
          for (int k = 0; k < 2; k++)
          begin
            if (intProd[k][DATA_W-1:HALF_W-1] != {17{intProd[k][HALF_W-1]}})
            begin
              lanes[(1-k)*HALF_W +: HALF_W] = intProd[k][DATA_W-1] ? H16_MIN : H16_MAX;
            end
          end
        end
        next_st.destResult  = lanes;
        next_st.resultValid = 1'b1;
      end
      else if (opCode <= OP_RIGHT_MAC_SAT)
      begin
        unique case (opCode)
          OP_DOT_SUB:      sat = clamped[PROD_HI] | clamped[PROD_LO];
          OP_CROSS_SUB:    sat = clamped[PROD_XHL] | clamped[PROD_XLH];
          OP_CROSS_SUB_SAT:
          begin
            sat = clamped[PROD_XHL] | clamped[PROD_XLH] | wideOvf;
            if (wideOvf)
              newAcc = wideSum[ACC_W] ? ACC_MIN : ACC_MAX;
          end
          OP_CMPLX_STEP:   sat = clamped[PROD_HI] | clamped[PROD_LO];
          OP_LONG_ACC_SAT,
          OP_LONG_SUB_SAT:
          begin
            sat = longClamp | wideOvf;
            if (wideOvf)
              newAcc = wideSum[ACC_W] ? ACC_MIN : ACC_MAX;
          end
          OP_LEFT_MAC:     sat = clamped[PROD_HI];
          OP_RIGHT_MAC:    sat = clamped[PROD_LO];
          OP_LEFT_MAC_SAT,
          OP_RIGHT_MAC_SAT:
          begin
            sat = (opCode == OP_LEFT_MAC_SAT) ? clamped[PROD_HI] : clamped[PROD_LO];
            if (wideOvf || $signed(wrapSum) > $signed(Q31_MAX_ACC))
            begin
              newAcc = Q31_MAX_ACC;
              sat    = 1'b1;
            end
            else if (wideOvf || $signed(wrapSum) < $signed(Q31_MIN_ACC))
            begin
              newAcc = Q31_MIN_ACC;
              sat    = 1'b1;
            end
          end
          default:         sat = 1'b0;
        endcase
        if (opCode == OP_LEFT_MAC_SAT || opCode == OP_RIGHT_MAC_SAT)
        begin
          if (wideOvf)
            newAcc = wideSum[ACC_W] ? Q31_MIN_ACC : Q31_MAX_ACC;
        end
        next_st.acc[accSelect] = newAcc;
        next_st.accResult      = newAcc;
        next_st.resultValid    = 1'b1;
        next_st.resultToAcc    = 1'b1;
        if (sat)
          next_st.ovf[accSelect] = 1'b1;
      end
      else
      begin
        next_st.illegalOp = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st.acc         <= {NUM_ACC{ACC_RESET}};
      st.ovf         <= '0;
      st.readData    <= ACC_RESET;
      st.accResult   <= ACC_RESET;
      st.destResult  <= DEST_RESET;
      st.resultValid <= 1'b0;
      st.resultToAcc <= 1'b0;
      st.illegalOp   <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign accReadData = st.readData;
  assign resultValid = st.resultValid;
  assign resultToAcc = st.resultToAcc;
  assign accResult   = st.accResult;
  assign destResult  = st.destResult;
  assign illegalOp   = st.illegalOp;
  assign ovfFlag     = st.ovf;

  chk_dot_subtract: assert property (
    @(posedge clk) disable iff (!reset_n)
    opValid && opCode == OP_DOT_SUB
    |=> accResult == $past(accNow) - $past(straightSum) && st.acc[$past(accSelect)] == accResult)
    else $error("dot subtract result wrong");

  chk_q15_clamp: assert property (
    @(posedge clk) disable iff (!reset_n)
    firstSource[HALF_W-1:0] == Q15_MINUS_ONE && secondSource[HALF_W-1:0] == Q15_MINUS_ONE
    |-> fracProd[PROD_LO] == Q31_MAX)
    else $error("q15 minus one product not clamped");

  chk_cmplx_step: assert property (
    @(posedge clk) disable iff (!reset_n)
    opValid && opCode == OP_CMPLX_STEP
    |=> resultToAcc && accResult == $past(accNow) + $past(cmplxDiff))
    else $error("complex step result wrong");

  chk_long_clamp: assert property (
    @(posedge clk) disable iff (!reset_n)
    longClamp |-> fracLong == Q63_MAX)
    else $error("q31 minus one product not clamped");

  chk_long_sat: assert property (
    @(posedge clk) disable iff (!reset_n)
    opValid && (opCode == OP_LONG_ACC_SAT || opCode == OP_LONG_SUB_SAT) && wideOvf
    |=> (accResult == ACC_MAX || accResult == ACC_MIN) && ovfFlag[$past(accSelect)])
    else $error("long form overflow not saturated");

  chk_mac_range: assert property (
    @(posedge clk) disable iff (!reset_n)
    opValid && (opCode == OP_LEFT_MAC_SAT || opCode == OP_RIGHT_MAC_SAT)
    |=> $signed(accResult) <= $signed(Q31_MAX_ACC) && $signed(accResult) >= $signed(Q31_MIN_ACC))
    else $error("saturating mac left q31 range");

  chk_lane_mul: assert property (
    @(posedge clk) disable iff (!reset_n)
    opValid && revisionTwo && opCode == OP_LANE_MUL
    |=> resultValid && !resultToAcc
        && destResult == $past(laneTrunc))
    else $error("lane multiply result wrong");

  chk_rev_gate: assert property (
    @(posedge clk) disable iff (!reset_n)
    opValid && revOp && !revisionTwo
    |=> illegalOp && !resultValid && st.acc == $past(st.acc))
    else $error("second-revision operation not refused");

  chk_sticky_ovf: assert property (
    @(posedge clk) disable iff (!reset_n)
    opValid && opCode == OP_LEFT_MAC && clamped[PROD_HI]
    |=> ovfFlag[$past(accSelect)])
    else $error("sticky overflow flag not set");

  chk_sticky_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    |ovfFlag |=> &(ovfFlag | ~$past(ovfFlag) | $past(ovfClear)))
    else $error("sticky overflow flag lost without clear");

  chk_lane_sat: assert property (
    @(posedge clk) disable iff (!reset_n)
    opValid && revisionTwo && opCode == OP_LANE_MUL_SAT && $signed(intProd[PROD_HI]) > 32'sh0000_7fff
    |=> destResult[DATA_W-1:HALF_W] == H16_MAX)
    else $error("lane multiply upper lane not clamped");

  chk_cross_sat: assert property (
    @(posedge clk) disable iff (!reset_n)
    opValid && revisionTwo && opCode == OP_CROSS_SUB_SAT && wideOvf
    |=> accResult == ACC_MAX || accResult == ACC_MIN)
    else $error("crossed subtract overflow not saturated");

  chk_illegal_code: assert property (
    @(posedge clk) disable iff (!reset_n)
    opValid && opCode > OP_LANE_MUL_SAT
    |=> illegalOp && !resultValid)
    else $error("undefined operation code not refused");

endmodule : fpmac_datapath
`default_nettype wire

// ===== fpmac_core_model.sv
// register file and writeback model of the issuing core
`timescale 1ns/1ps
`default_nettype none
module fpmac_core_model
  import fpmac_pkg::*;
(
  input  wire logic              clk,          // processor clock
  input  wire logic              reset_n,      // asynchronous reset, active low
  input  wire logic [1:0]        rdA,          // first source index
  input  wire logic [1:0]        rdB,          // second source index
  input  wire logic              opValid,      // operation issued
  input  wire logic [1:0]        wbIdx,        // destination index of the issued op
  input  wire logic              resultValid,  // result pulse
  input  wire logic              resultToAcc,  // result went to an accumulator
  input  wire logic [DATA_W-1:0] destResult,   // lane multiply result
  input  wire logic              ldEn,         // preload a register
  input  wire logic [1:0]        ldIdx,        // preload index
  input  wire logic [DATA_W-1:0] ldData,       // preload value
  output logic      [DATA_W-1:0] firstSource,  // first source value
  output logic      [DATA_W-1:0] secondSource  // second source value
);
  logic [DATA_W-1:0] regFile [4];
  logic [1:0]        wbHeld;
  assign firstSource  = regFile[rdA];
  assign secondSource = regFile[rdB];
  // writeback lands one edge after the result pulse; a preload to the same index wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wbHeld <= 2'h0;
      for (int i = 0; i < 4; i++) regFile[i] <= 32'h0000_0000;
    end
    else
    begin
      if (opValid) wbHeld <= wbIdx;
      if (resultValid && !resultToAcc) regFile[wbHeld] <= destResult;
      if (ldEn) regFile[ldIdx] <= ldData;
    end
  end
endmodule : fpmac_core_model
`default_nettype wire

// ===== test_fixed_point_mac_datapath.sv
// self-checking bench for the fixed-point multiply-accumulate datapath
`timescale 1ns/1ps
`default_nettype none
module test_fixed_point_mac_datapath import fpmac_pkg::*;;
  logic        clk = 1'b0, reset_n = 1'b0, revisionTwo = 1'b0, opValid = 1'b0, ldEn = 1'b0, pendWb = 1'b0;
  logic [3:0]  opCode = 4'h0, ovfClear = 4'h0, flagRef = 4'h0, ovfFlag;
  logic [1:0]  accSelect = 2'h0, accReadSel = 2'h0, rdA = 2'h0, rdB = 2'h0, wbIdx = 2'h0, ldIdx = 2'h0, pendIdx = 2'h0;
  logic [31:0] ldData = 32'h0000_0000, pendVal = 32'h0000_0000, lastDest = 32'h0000_0000;
  logic [31:0] firstSource, secondSource, destResult;
  logic [63:0] lastAcc = 64'h0000_0000_0000_0000, accReadData, accResult;
  logic        resultValid, resultToAcc, illegalOp;
  logic [63:0] accRef [4] = '{default: '0};
  logic [31:0] regs [4] = '{default: '0};
  int          nErrors = 0, totalChecks = 0;

  always #10 clk = ~clk;

  fpmac_datapath uut (.clk(clk), .reset_n(reset_n), .revisionTwo(revisionTwo), .opValid(opValid), .opCode(opCode),
    .accSelect(accSelect), .firstSource(firstSource), .secondSource(secondSource), .ovfClear(ovfClear),
    .accReadSel(accReadSel), .accReadData(accReadData), .resultValid(resultValid), .resultToAcc(resultToAcc),
    .accResult(accResult), .destResult(destResult), .illegalOp(illegalOp), .ovfFlag(ovfFlag));
  fpmac_core_model core (.clk(clk), .reset_n(reset_n), .rdA(rdA), .rdB(rdB), .opValid(opValid), .wbIdx(wbIdx),
    .resultValid(resultValid), .resultToAcc(resultToAcc), .destResult(destResult), .ldEn(ldEn), .ldIdx(ldIdx),
    .ldData(ldData), .firstSource(firstSource), .secondSource(secondSource));

  task automatic reportAndStop;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : reportAndStop

  task automatic check_acc(input logic [63:0] got, input logic [63:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("wrong value at %0t: accumulator %h expected %h", $time, got, exp);
    end
  endtask : check_acc

  task automatic check_dest(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("wrong value at %0t: destination %h expected %h", $time, got, exp);
    end
  endtask : check_dest

  task automatic check_bits(input logic [3:0] got, input logic [3:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("wrong value at %0t: flags %b expected %b", $time, got, exp);
    end
  endtask : check_bits

  function automatic logic [65:0] sx(input logic [31:0] v);
    return {{34{v[31]}}, v};
  endfunction : sx

  function automatic logic [31:0] fq15(input logic [15:0] a, input logic [15:0] b, output logic c);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    c = (a == Q15_MINUS_ONE) && (b == Q15_MINUS_ONE);
    return c ? Q31_MAX : p <<< 1;
  endfunction : fq15

  function automatic logic [15:0] lane(input logic [15:0] a, input logic [15:0] b, input logic s);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    if (s && p > 32'sh0000_7fff) return H16_MAX;
    if (s && p < -32'sh0000_8000) return H16_MIN;
    return p[15:0];
  endfunction : lane

  function automatic logic [63:0] sat(input logic [65:0] v, input logic [63:0] lo, input logic [63:0] hi,
                                      inout logic c);
    logic signed [65:0] s, l, h;
    s = v;
    l = {{2{lo[63]}}, lo};
    h = {{2{hi[63]}}, hi};
    c = c | (s > h) | (s < l);
    return (s > h) ? hi : (s < l) ? lo : v[63:0];
  endfunction : sat

  function automatic void predict(input logic [3:0] op, input logic [63:0] acc, input logic [31:0] a, b,
                                  output logic [63:0] na, output logic [31:0] nd, output logic c);
    logic [65:0]        e;
    logic [31:0]        ph, pl, px, py;
    logic signed [63:0] q;
    logic               ch, cl, cx, cy, cq;
    e  = {{2{acc[63]}}, acc};
    ph = fq15(a[31:16], b[31:16], ch);
    pl = fq15(a[15:0], b[15:0], cl);
    px = fq15(a[31:16], b[15:0], cx);
    py = fq15(a[15:0], b[31:16], cy);
    q  = $signed(a) * $signed(b);
    cq = (a == Q31_MINUS_ONE) && (b == Q31_MINUS_ONE);
    q  = cq ? Q63_MAX : q <<< 1;
    case (op)
      4'h0, 4'h3: c = ch | cl;
      4'h1, 4'h2: c = cx | cy;
      4'h4, 4'h5: c = cq;
      4'h6, 4'h8: c = ch;
      4'h7, 4'h9: c = cl;
      default:    c = 1'b0;
    endcase
    nd = {lane(a[31:16], b[31:16], op[0]), lane(a[15:0], b[15:0], op[0])};
    case (op)
      4'h0:    na = 64'(e - sx(ph) - sx(pl));
      4'h1:    na = 64'(e - sx(px) - sx(py));
      4'h2:    na = sat(e - sx(px) - sx(py), ACC_MIN, ACC_MAX, c);
      4'h3:    na = 64'(e + sx(ph) - sx(pl));
      4'h4:    na = sat(e + {{2{q[63]}}, q}, ACC_MIN, ACC_MAX, c);
      4'h5:    na = sat(e - {{2{q[63]}}, q}, ACC_MIN, ACC_MAX, c);
      4'h6:    na = 64'(e + sx(ph));
      4'h7:    na = 64'(e + sx(pl));
      4'h8:    na = sat(e + sx(ph), Q31_MIN_ACC, Q31_MAX_ACC, c);
      4'h9:    na = sat(e + sx(pl), Q31_MIN_ACC, Q31_MAX_ACC, c);
      default: na = acc;
    endcase
  endfunction : predict

  // one issued operation; opValid stays high so calls run back to back
  task automatic do_op(input logic [3:0] op, input logic [1:0] acc, ra, rb, input logic rev,
                       input logic [1:0] wi, input logic le, input logic [1:0] li, input logic [31:0] ld);
    logic [63:0] na;
    logic [31:0] nd;
    logic        c, ok, toAcc;
    ok    = op <= 4'hb && (rev || !(op inside {4'h2, 4'ha, 4'hb}));
    toAcc = op <= 4'h9;
    predict(op, accRef[acc], regs[ra], regs[rb], na, nd, c);
    {opValid, opCode, accSelect, rdA, rdB, revisionTwo, wbIdx} = {1'b1, op, acc, ra, rb, rev, wi};
    {ldEn, ldIdx, ldData, ovfClear, accReadSel} = {le, li, ld, 4'h0, acc};
    @(negedge clk);
    check_acc(accReadData, accRef[acc]);
    lastAcc      = (ok && toAcc) ? na : lastAcc;
    accRef[acc]  = (ok && toAcc) ? na : accRef[acc];
    flagRef[acc] = flagRef[acc] | (ok && toAcc && c);
    lastDest     = (ok && !toAcc) ? nd : lastDest;
    check_bits({1'b0, resultValid, illegalOp, resultToAcc | !ok}, {1'b0, ok, !ok, toAcc | !ok});
    check_acc(accResult, lastAcc);
    check_dest(destResult, lastDest);
    check_bits(ovfFlag, flagRef);
    regs[pendIdx] = pendWb ? pendVal : regs[pendIdx];
    regs[li]      = le ? ld : regs[li];
    {pendWb, pendIdx, pendVal} = {ok && !toAcc, wi, nd};
  endtask : do_op

  task automatic idle(input logic [3:0] clr, input logic [1:0] rs);
    {opValid, ldEn, ovfClear, accReadSel} = {1'b0, 1'b0, clr, rs};
    @(negedge clk);
    flagRef = flagRef & ~clr;
    check_bits(ovfFlag, flagRef);
    check_acc(accReadData, accRef[rs]);
    check_bits({2'h0, resultValid, illegalOp}, 4'h0);
    regs[pendIdx] = pendWb ? pendVal : regs[pendIdx];
    pendWb = 1'b0;
  endtask : idle

  initial
  begin
    #1000000;
    nErrors++;
    reportAndStop;
  end

  initial
  begin
    logic [31:0] corner [4];
    logic [3:0]  op;
    corner = '{32'h8000_8000, 32'h8000_0000, 32'h7fff_8000, 32'h0001_ffff};
    void'($urandom(95473));
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    check_acc(accResult, ACC_RESET);
    check_dest(destResult, DEST_RESET);
    // refused codes carry the corner preloads
    for (int i = 0; i < 4; i++)
      do_op(4'hc + 4'(i), 2'(i), 2'h0, 2'h0, 1'b1, 2'h0, 1'b1, 2'(i), corner[i]);
    idle(4'h0, 2'h0);
    for (int s = 0; s < 4; s++)
      for (int i = 0; i < 12; i++)
        do_op(4'(i), 2'(i), 2'(s), 2'(s % 2), 1'b1, 2'h3, 1'b0, 2'h0, 32'h0000_0000);
    // drive accumulators into both saturation limits
    for (int i = 0; i < 12; i++)
    begin
      op = (i < 3) ? 4'h4 : (i < 9) ? 4'h5 : 4'h8;
      do_op(op, op[1:0], op[2] ? 2'h1 : 2'h0, op[2] ? 2'h1 : 2'h0, 1'b1, 2'h3, 1'b0, 2'h0, 32'h0000_0000);
    end
    // push acc2 to its top, then a crossed saturating subtract overflows it
    for (int i = 0; i < 4; i++)
      do_op(i < 3 ? 4'h4 : 4'h2, 2'h2, i < 3 ? 2'h1 : 2'h2, i < 3 ? 2'h1 : 2'h2, 1'b1, 2'h3, 1'b0, 2'h0, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
      do_op(i == 0 ? 4'h2 : 4'h9 + 4'(i), 2'h1, 2'h0, 2'h0, 1'b0, 2'h3, 1'b0, 2'h0, 32'h0000_0000);
    idle(4'hf, 2'h1);
    repeat (1500)
    begin
      if ($urandom % 8 == 0)
        idle(4'($urandom), 2'($urandom));
      else
        do_op(4'($urandom), 2'($urandom), 2'($urandom), 2'($urandom), ($urandom % 4) != 0, 2'($urandom),
              1'($urandom), 2'($urandom), ($urandom % 3 == 0) ? corner[2'($urandom)] : $urandom);
    end
    reportAndStop;
  end
endmodule : test_fixed_point_mac_datapath
`default_nettype wire
